/* common/tmc_pkg.sv */
// Shared constants for the 16-bit timer counter and capture core
package tmc_pkg;
  // Byte port addresses
  localparam logic [3:0] ADR_CNT_LO = 4'h0; // Counter low byte, triggers 16-bit access
  localparam logic [3:0] ADR_CNT_HI = 4'h1; // Counter high byte, goes through the latch
  localparam logic [3:0] ADR_CAP_LO = 4'h2; // Capture low byte
  localparam logic [3:0] ADR_CAP_HI = 4'h3; // Capture high byte, goes through the latch
  localparam logic [3:0] ADR_CMPA_LO = 4'h4; // Compare A low byte
  localparam logic [3:0] ADR_CMPA_HI = 4'h5; // Compare A high byte, direct on read
  localparam logic [3:0] ADR_CMPB_LO = 4'h6; // Compare B low byte
  localparam logic [3:0] ADR_CMPB_HI = 4'h7; // Compare B high byte, direct on read
  localparam logic [3:0] ADR_CTRL_A = 4'h8; // Control register A
  localparam logic [3:0] ADR_CTRL_B = 4'h9; // Control register B
  localparam logic [3:0] ADR_FLAGS = 4'ha; // Event flags, write one to clear
  localparam logic [3:0] ADR_MASK = 4'hb; // Interrupt enables

  // Field positions
  localparam int CTRLA_WGM_LSB = 0; // Mode bits 1:0 in control A
  localparam int CTRLB_CS_LSB = 0; // Clock select 2:0 in control B
  localparam int CTRLB_WGM_LSB = 3; // Mode bits 3:2 in control B
  localparam int CTRLB_EDGE_BIT = 6; // Capture edge sense, 1 = rising
  localparam int FLAG_OVF_BIT = 0; // Overflow flag / enable position
  localparam int FLAG_CAP_BIT = 5; // Capture flag / enable position

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Count limits
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler taps, as masks of a free-running 10-bit divider
  localparam logic [9:0] PRE_MASK8 = 10'h007;
  localparam logic [9:0] PRE_MASK64 = 10'h03f;
  localparam logic [9:0] PRE_MASK256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK1024 = 10'h3ff;
endpackage

/* common/tmc_evt_if.sv */
// Event carrier between the tick and capture sources and the core
interface tmc_evt_if;
  logic tick; // One-cycle timer tick enable
  logic cap_hit; // One-cycle qualified capture edge

  modport tick_src (output tick);
  modport cap_src (output cap_hit);
  modport sink (input tick, input cap_hit);
endinterface

/* src/tmc_tick_sel.sv */
// Timer clock selection: prescaler taps and external pin edges
module tmc_tick_sel
  import tmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] cs_in,
  input wire logic ext_pin_in,
  tmc_evt_if.tick_src evt
);
  logic [9:0] pre_ff; // Free-running prescaler
  logic ext_prev_ff; // Previous external pin level
  logic nxt_tick; // Selected enable

  // Divider runs always; ticks land on fixed phases of it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= pre_ff + 10'h001;
    end
  end

  // Edge history of the external pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_pin_in;
    end
  end

  // Source choice by the clock select field
  always_comb begin
    unique case (cs_in)
      CS_STOP: nxt_tick = 1'b0;
      CS_DIV1: nxt_tick = 1'b1;
      CS_DIV8: nxt_tick = (pre_ff & PRE_MASK8) == PRE_MASK8;
      CS_DIV64: nxt_tick = (pre_ff & PRE_MASK64) == PRE_MASK64;
      CS_DIV256: nxt_tick = (pre_ff & PRE_MASK256) == PRE_MASK256;
      CS_DIV1024: nxt_tick = (pre_ff & PRE_MASK1024) == PRE_MASK1024;
      CS_EXT_FALL: nxt_tick = ext_prev_ff & ~ext_pin_in;
      CS_EXT_RISE: nxt_tick = ~ext_prev_ff & ext_pin_in;
    endcase
  end

  assign evt.tick = nxt_tick;
endmodule

/* src/tmc_cap_edge.sv */
// Capture source mux and edge sense detector
module tmc_cap_edge (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic comp_in,
  input wire logic use_comp_in,
  input wire logic rise_in,
  input wire logic enable_in,
  tmc_evt_if.cap_src evt
);
  logic src; // Selected trigger source
  logic prev_ff; // Previous source level

  assign src = use_comp_in ? comp_in : pin_in;

  // Source history; a change of source itself may look like an edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= src;
    end
  end

  // Edge must match the configured sense
  assign evt.cap_hit = enable_in & (rise_in ? (~prev_ff & src) : (prev_ff & ~src));
endmodule

/* src/tmc_core.sv */
// 16-bit timer core: counter, shared high-byte latch, capture unit
module tmc_core
  import tmc_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic RD_IN,
  input wire logic WR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic EXT_CLK_PIN_IN,
  input wire logic CAPTURE_INPUT_PIN_IN,
  input wire logic COMPARATOR_OUTPUT_IN,
  input wire logic CAP_SEL_COMPARATOR_IN,
  input wire logic OVF_IRQ_ACK_IN,
  input wire logic CAP_IRQ_ACK_IN,
  output logic [7:0] RDATA_OUT,
  output logic OVF_IRQ_OUT,
  output logic CAP_IRQ_OUT,
  output logic TOP_OUT,
  output logic BOTTOM_OUT,
  output logic COUNT_DOWN_OUT,
  output logic [3:0] WAVE_MODE_OUT
);
  // Register state
  logic [7:0] temp_ff; // Shared high-byte latch
  logic [15:0] cnt_ff; // Counter value
  logic [15:0] cap_ff; // Capture value
  logic [15:0] cmpa_ff; // Compare A value
  logic [15:0] cmpb_ff; // Compare B value
  logic [7:0] ctrla_ff; // Control register A
  logic [7:0] ctrlb_ff; // Control register B
  logic down_ff; // Direction, 1 = decrement
  logic ovf_flag_ff; // Overflow flag
  logic cap_flag_ff; // Capture flag
  logic ovf_en_ff; // Overflow interrupt enable
  logic cap_en_ff; // Capture interrupt enable

  // Next values and decoded terms
  logic [15:0] nxt_cnt;
  logic nxt_down;
  logic ovf_evt; // Overflow point reached this cycle
  logic [3:0] wgm; // Mode field, joined from A and B
  logic [2:0] cs; // Clock select field
  logic [15:0] top; // Current top value
  logic wr_cnt_lo; // Counter low write strobe
  logic wr_cap_lo; // Capture low write strobe
  logic rd_cnt_lo; // Counter low read strobe
  logic rd_cap_lo; // Capture low read strobe
  logic wr_hi; // Any high-byte write

  tmc_evt_if evt ();

  // Mode field split over both control registers
  assign wgm = {ctrlb_ff[CTRLB_WGM_LSB + 1 -: 2], ctrla_ff[CTRLA_WGM_LSB + 1 -: 2]};
  assign cs = ctrlb_ff[CTRLB_CS_LSB + 2 -: 3];

  // Modes counting up and down
  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  endfunction

  // Modes whose top is held in the capture register
  function automatic logic is_cap_top(input logic [3:0] m);
    is_cap_top = (m inside {4'h8, 4'ha, 4'hc, 4'he});
  endfunction

  // Single-slope modes that overflow at top rather than at max
  function automatic logic ovf_at_top(input logic [3:0] m);
    ovf_at_top = (m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
  endfunction

  // Top value for a mode
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                         input logic [15:0] cp);
    unique case (m)
      4'h1, 4'h5: top_of = TOP_8BIT;
      4'h2, 4'h6: top_of = TOP_9BIT;
      4'h3, 4'h7: top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_of = ca;
      4'h8, 4'ha, 4'hc, 4'he: top_of = cp;
      default: top_of = CNT_MAX; // Normal and the reserved code
    endcase
  endfunction

  assign top = top_of(wgm, cmpa_ff, cap_ff);

  // Access strobes, taken on the edge of the access
  assign wr_cnt_lo = WR_IN && (ADDR_IN == ADR_CNT_LO);
  assign wr_cap_lo = WR_IN && (ADDR_IN == ADR_CAP_LO) && is_cap_top(wgm);
  assign rd_cnt_lo = RD_IN && (ADDR_IN == ADR_CNT_LO);
  assign rd_cap_lo = RD_IN && (ADDR_IN == ADR_CAP_LO);
  assign wr_hi = WR_IN && (ADDR_IN inside {ADR_CNT_HI, ADR_CAP_HI, ADR_CMPA_HI, ADR_CMPB_HI});

  // Timer tick source
  tmc_tick_sel u_tick (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(NRST_IN),
    .cs_in(cs),
    .ext_pin_in(EXT_CLK_PIN_IN),
    .evt(evt.tick_src)
  );

  // Capture edge source; input idle while capture holds top
  tmc_cap_edge u_cap (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(NRST_IN),
    .pin_in(CAPTURE_INPUT_PIN_IN),
    .comp_in(COMPARATOR_OUTPUT_IN),
    .use_comp_in(CAP_SEL_COMPARATOR_IN),
    .rise_in(ctrlb_ff[CTRLB_EDGE_BIT]),
    .enable_in(!is_cap_top(wgm)),
    .evt(evt.cap_src)
  );

  // Shared latch: loaded by high writes and by counter or capture low reads only
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      temp_ff <= RST_BYTE;
    end else if (wr_hi) begin
      temp_ff <= WDATA_IN;
    end else if (rd_cnt_lo) begin
      temp_ff <= cnt_ff[15:8];
    end else if (rd_cap_lo) begin
      temp_ff <= cap_ff[15:8];
    end
    // Low writes leave it alone so one high byte serves many
  end

  // Counter sequence; a port write wins over any tick
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_down = down_ff;
    ovf_evt = 1'b0;
    if (wr_cnt_lo) begin
      nxt_cnt = {temp_ff, WDATA_IN};
    end else if (evt.tick) begin
      if (is_dual(wgm)) begin
        // Up to top, then down to bottom
        if (!down_ff) begin
          if (cnt_ff >= top) begin
            nxt_down = 1'b1;
            nxt_cnt = cnt_ff - 16'h0001;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end else if (cnt_ff == CNT_BOTTOM) begin
          // Reached only after a write; turn round
          nxt_down = 1'b0;
          nxt_cnt = cnt_ff + 16'h0001;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001) begin
            nxt_down = 1'b0;
            ovf_evt = 1'b1;
          end
        end
      end else begin
        // Single slope always counts up
        nxt_down = 1'b0;
        if (cnt_ff == CNT_MAX) begin
          nxt_cnt = CNT_BOTTOM;
          ovf_evt = 1'b1;
        end else if (cnt_ff == top) begin
          nxt_cnt = CNT_BOTTOM;
          ovf_evt = ovf_at_top(wgm);
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
    end
  end

  // Counter and direction state
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt_ff <= RST_WORD;
      down_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      down_ff <= nxt_down;
    end
  end

  // Capture register: an edge stamps the counter, writes only in top modes
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cap_ff <= RST_WORD;
    end else if (evt.cap_hit) begin
      cap_ff <= cnt_ff;
    end else if (wr_cap_lo) begin
      cap_ff <= {temp_ff, WDATA_IN};
    end
  end

  // Compare registers written through the latch, control registers plain byte writes
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cmpa_ff <= RST_WORD;
      cmpb_ff <= RST_WORD;
      ctrla_ff <= RST_BYTE;
      ctrlb_ff <= RST_BYTE;
    end else if (WR_IN) begin
      if (ADDR_IN == ADR_CMPA_LO) begin
        cmpa_ff <= {temp_ff, WDATA_IN};
      end
      if (ADDR_IN == ADR_CMPB_LO) begin
        cmpb_ff <= {temp_ff, WDATA_IN};
      end
      if (ADDR_IN == ADR_CTRL_A) begin
        ctrla_ff <= WDATA_IN;
      end
      if (ADDR_IN == ADR_CTRL_B) begin
        ctrlb_ff <= WDATA_IN;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ovf_en_ff <= 1'b0;
      cap_en_ff <= 1'b0;
    end else if (WR_IN && (ADDR_IN == ADR_MASK)) begin
      ovf_en_ff <= WDATA_IN[FLAG_OVF_BIT];
      cap_en_ff <= WDATA_IN[FLAG_CAP_BIT];
    end
  end

  // Flags: a new event beats a clear in the same cycle
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ovf_flag_ff <= 1'b0;
      cap_flag_ff <= 1'b0;
    end else begin
      if (ovf_evt) begin
        ovf_flag_ff <= 1'b1;
      end else if (OVF_IRQ_ACK_IN ||
                   (WR_IN && (ADDR_IN == ADR_FLAGS) && WDATA_IN[FLAG_OVF_BIT])) begin
        ovf_flag_ff <= 1'b0;
      end
      if (evt.cap_hit) begin
        cap_flag_ff <= 1'b1;
      end else if (CAP_IRQ_ACK_IN) begin
        cap_flag_ff <= 1'b0;
      end else if (WR_IN && (ADDR_IN == ADR_FLAGS) && WDATA_IN[FLAG_CAP_BIT]) begin
        cap_flag_ff <= 1'b0;
      end
    end
  end

  // Interrupt requests, registered from flag and enable
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      OVF_IRQ_OUT <= 1'b0;
      CAP_IRQ_OUT <= 1'b0;
    end else begin
      OVF_IRQ_OUT <= ovf_flag_ff & ovf_en_ff;
      CAP_IRQ_OUT <= cap_flag_ff & cap_en_ff;
    end
  end

  // Indications aligned with the counter value they describe
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TOP_OUT <= 1'b0;
      BOTTOM_OUT <= 1'b1;
      COUNT_DOWN_OUT <= 1'b0;
      WAVE_MODE_OUT <= 4'h0;
    end else begin
      TOP_OUT <= (nxt_cnt == top);
      BOTTOM_OUT <= (nxt_cnt == CNT_BOTTOM);
      COUNT_DOWN_OUT <= nxt_down;
      WAVE_MODE_OUT <= wgm;
    end
  end

  // Read data, answered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= RST_BYTE;
    end else if (RD_IN) begin
      unique case (ADDR_IN)
        ADR_CNT_LO: RDATA_OUT <= cnt_ff[7:0];
        ADR_CNT_HI: RDATA_OUT <= temp_ff;
        ADR_CAP_LO: RDATA_OUT <= cap_ff[7:0];
        ADR_CAP_HI: RDATA_OUT <= temp_ff;
        ADR_CMPA_LO: RDATA_OUT <= cmpa_ff[7:0];
        ADR_CMPA_HI: RDATA_OUT <= cmpa_ff[15:8];
        ADR_CMPB_LO: RDATA_OUT <= cmpb_ff[7:0];
        ADR_CMPB_HI: RDATA_OUT <= cmpb_ff[15:8];
        ADR_CTRL_A: RDATA_OUT <= ctrla_ff;
        ADR_CTRL_B: RDATA_OUT <= ctrlb_ff;
        ADR_FLAGS: RDATA_OUT <= 8'({cap_flag_ff, 4'h0, ovf_flag_ff} << FLAG_OVF_BIT);
        ADR_MASK: RDATA_OUT <= 8'({cap_en_ff, 4'h0, ovf_en_ff} << FLAG_OVF_BIT);
        default: RDATA_OUT <= RST_BYTE;
      endcase
    end
  end

  // Checks
  latch_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    wr_cnt_lo |=> temp_ff == $past(temp_ff))
    else $error("latch changed by low write");
  hi_read_latch_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    RD_IN && ADDR_IN == ADR_CNT_HI |=> RDATA_OUT == $past(temp_ff))
    else $error("counter high read not from latch");
  lo_read_load_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    rd_cnt_lo && !WR_IN |=> temp_ff == $past(cnt_ff[15:8]))
    else $error("latch not loaded on low read");
  stop_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    cs == CS_STOP && !WR_IN ##1 !WR_IN |-> $stable(cnt_ff))
    else $error("counter moved while stopped");
  write_wins_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    wr_cnt_lo |=> cnt_ff == {$past(temp_ff), $past(WDATA_IN)})
    else $error("counter write lost");
  normal_count_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    evt.tick && wgm == 4'h0 && !wr_cnt_lo |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("normal mode did not increment");
  capture_stamp_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    evt.cap_hit |=> cap_ff == $past(cnt_ff) && cap_flag_ff)
    else $error("capture value or flag wrong");
  flag_clear_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    WR_IN && ADDR_IN == ADR_FLAGS && WDATA_IN[FLAG_CAP_BIT] && !evt.cap_hit |=> !cap_flag_ff)
    else $error("capture flag not cleared");
  cap_guard_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    WR_IN && ADDR_IN == ADR_CAP_LO && !is_cap_top(wgm) && !evt.cap_hit |=> $stable(cap_ff))
    else $error("capture written outside top modes");
  cap_irq_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    cap_flag_ff && cap_en_ff |=> CAP_IRQ_OUT)
    else $error("capture interrupt missing");
  cmp_direct_a: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    RD_IN && ADDR_IN == ADR_CMPA_HI |=> RDATA_OUT == $past(cmpa_ff[15:8]))
    else $error("compare high read via latch");
endmodule

/* tb/tmc_cpu_model.sv */
// CPU side byte bus model for the timer core register port
module tmc_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [3:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic ovf_ack_out,
  output logic cap_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    addr_out = 4'h0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    ovf_ack_out = 1'b0;
    cap_ack_out = 1'b0;
  end
  // One write strobe held over one sampling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d; // Released data stops showing the old value
  endtask
  // One read; data taken once the answer has settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    @(negedge clk_in);
    d = rdata_in;
  endtask
  // Word write, high byte first; no other access in between
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // Word read, low byte first; no other access in between
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask
  // Interrupt serviced: one cycle acknowledge pulse
  task automatic ack(input logic cap);
    @(negedge clk_in);
    if (cap) begin
      cap_ack_out = 1'b1;
    end else begin
      ovf_ack_out = 1'b1;
    end
    @(negedge clk_in);
    cap_ack_out = 1'b0;
    ovf_ack_out = 1'b0;
  endtask
endmodule

/* tb/timer16_counter_capture_core_tb_top.sv */
// Self-checking bench for the 16-bit timer core
module timer16_counter_capture_core_tb_top
  import tmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst_n, ext, pin, comp, csel; // Bench driven inputs
  logic [3:0] addr, wmode;
  logic rd, wr, oack, cack, oirq, cirq, top, bot, down;
  logic [7:0] wd, rdat, b;
  logic [15:0] w;
  int err_total = 0;
  int total_checks = 0;

  tmc_core uut (.SYS_CLK_IN(clk), .NRST_IN(nrst_n), .ADDR_IN(addr), .RD_IN(rd),
    .WR_IN(wr), .WDATA_IN(wd), .EXT_CLK_PIN_IN(ext), .CAPTURE_INPUT_PIN_IN(pin),
    .COMPARATOR_OUTPUT_IN(comp), .CAP_SEL_COMPARATOR_IN(csel),
    .OVF_IRQ_ACK_IN(oack), .CAP_IRQ_ACK_IN(cack), .RDATA_OUT(rdat),
    .OVF_IRQ_OUT(oirq), .CAP_IRQ_OUT(cirq), .TOP_OUT(top), .BOTTOM_OUT(bot),
    .COUNT_DOWN_OUT(down), .WAVE_MODE_OUT(wmode));
  tmc_cpu_model cpu (.clk_in(clk), .rdata_in(rdat), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wd), .ovf_ack_out(oack), .cap_ack_out(cack));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // One compare for every kind of result
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Both control registers: mode, clock select, edge sense
  task automatic set_mode(input logic [3:0] m, input logic [2:0] cs, input logic rise);
    cpu.wr(ADR_CTRL_A, {6'h00, m[1:0]});
    cpu.wr(ADR_CTRL_B, {1'b0, rise, 1'b0, m[3:2], cs});
    @(negedge clk); // Mode output lags control B by one cycle
  endtask
  // Counts and verdict, single end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset state of the outputs
  task automatic t_reset();
    chk("bottom", 16'h0001, {15'h0, bot});
    chk("top", 16'h0000, {15'h0, top});
    chk("irqs", 16'h0000, {14'h0, oirq, cirq});
    cpu.rd16(ADR_CNT_LO, w);
    chk("cnt_rst", RST_WORD, w);
    $display("t_reset done");
  endtask
  // Word access while stopped; unmapped read
  task automatic t_word();
    cpu.wr16(ADR_CNT_LO, 16'h1234);
    repeat (5) @(negedge clk);
    cpu.rd16(ADR_CNT_LO, w);
    chk("cnt_word", 16'h1234, w);
    cpu.rd(4'hc, b);
    chk("unmapped", 16'h0000, {8'h0, b});
    $display("t_word done");
  endtask
  // One high byte shared by two low writes; compare high bypasses latch
  task automatic t_latch();
    cpu.wr(ADR_CNT_HI, 8'hab);
    cpu.wr(ADR_CNT_LO, 8'h01);
    cpu.wr(ADR_CMPA_LO, 8'h02);
    cpu.rd(ADR_CAP_LO, b);
    cpu.rd(ADR_CMPA_HI, b);
    chk("cmpa_hi", 16'h00ab, {8'h0, b});
    cpu.rd16(ADR_CNT_LO, w);
    chk("cnt_shared", 16'hab01, w);
    $display("t_latch done");
  endtask
  // External rising edges drive the count
  task automatic t_ext();
    ext = 1'b0;
    cpu.wr16(ADR_CNT_LO, 16'h0100);
    set_mode(4'h0, CS_EXT_RISE, 1'b0);
    repeat (3) begin
      ext = 1'b1;
      repeat (4) @(negedge clk);
      ext = 1'b0;
      repeat (4) @(negedge clk);
    end
    cpu.wr(ADR_CTRL_B, 8'h00);
    cpu.rd16(ADR_CNT_LO, w);
    chk("ext_count", 16'h0103, w);
    // Divide by 8 over 64 edges gives 8 ticks whatever the divider phase
    cpu.wr16(ADR_CNT_LO, 16'h0000);
    cpu.wr(ADR_CTRL_B, {5'h00, CS_DIV8});
    repeat (62) @(negedge clk);
    cpu.wr(ADR_CTRL_B, 8'h00);
    cpu.rd16(ADR_CNT_LO, w);
    chk("div8_count", 16'h0008, w);
    $display("t_ext done");
  endtask
  // Wrap at max sets overflow; write wins over running count
  task automatic t_ovf();
    cpu.wr16(ADR_CNT_LO, 16'hfffd);
    cpu.wr(ADR_FLAGS, 8'h01);
    cpu.wr(ADR_MASK, 8'h01);
    cpu.wr(ADR_CTRL_B, {5'h00, CS_DIV1});
    repeat (8) @(negedge clk);
    cpu.wr16(ADR_CNT_LO, 16'h0040);
    cpu.wr(ADR_CTRL_B, 8'h00);
    cpu.rd16(ADR_CNT_LO, w);
    chk("write_wins", 16'h0042, w);
    cpu.rd(ADR_FLAGS, b);
    chk("ovf_flag", 16'h0001, {15'h0, b[FLAG_OVF_BIT]});
    chk("ovf_irq", 16'h0001, {15'h0, oirq});
    cpu.ack(1'b0);
    repeat (2) @(negedge clk);
    chk("ovf_ack", 16'h0000, {15'h0, oirq});
    $display("t_ovf done");
  endtask
  // Dual slope mode turns down after its fixed top
  task automatic t_dual();
    set_mode(4'h1, CS_STOP, 1'b0);
    chk("mode1", 16'h0001, {12'h0, wmode});
    cpu.wr16(ADR_CNT_LO, 16'h00ff);
    repeat (2) @(negedge clk);
    chk("top_fixed", 16'h0001, {15'h0, top});
    cpu.wr16(ADR_CNT_LO, 16'h00fe);
    cpu.wr(ADR_CTRL_B, {5'h00, CS_DIV1});
    repeat (4) @(negedge clk);
    // Six ticks: up to 0xff, then down to 0xfa
    cpu.wr(ADR_CTRL_B, 8'h00);
    chk("down", 16'h0001, {15'h0, down});
    cpu.rd16(ADR_CNT_LO, w);
    chk("dual_range", 16'h00fa, w);
    $display("t_dual done");
  endtask
  // Edge captures from pin and comparator, flag, interrupt, clears
  task automatic t_cap();
    set_mode(4'h0, CS_STOP, 1'b1);
    cpu.wr16(ADR_CNT_LO, 16'h0500);
    cpu.wr(ADR_FLAGS, 8'h20);
    cpu.wr(ADR_MASK, 8'h20);
    pin = 1'b1;
    for (int i = 0; i < 8 && cirq !== 1'b1; i++) @(negedge clk);
    chk("cap_irq", 16'h0001, {15'h0, cirq});
    cpu.rd16(ADR_CAP_LO, w);
    chk("cap_pin", 16'h0500, w);
    cpu.ack(1'b1);
    repeat (2) @(negedge clk);
    chk("cap_ack", 16'h0000, {15'h0, cirq});
    pin = 1'b0;
    repeat (4) @(negedge clk);
    cpu.rd(ADR_FLAGS, b);
    chk("fall_ignored", 16'h0000, {15'h0, b[FLAG_CAP_BIT]});
    csel = 1'b1;
    cpu.wr16(ADR_CNT_LO, 16'h0600);
    comp = 1'b1;
    repeat (4) @(negedge clk);
    cpu.rd16(ADR_CAP_LO, w);
    chk("cap_comp", 16'h0600, w);
    cpu.wr(ADR_FLAGS, 8'h20);
    cpu.rd(ADR_FLAGS, b);
    chk("w1c", 16'h0000, {15'h0, b[FLAG_CAP_BIT]});
    $display("t_cap done");
  endtask
  // Capture register writable only as top
  task automatic t_captop();
    cpu.wr16(ADR_CAP_LO, 16'h0777);
    cpu.rd16(ADR_CAP_LO, w);
    chk("cap_locked", 16'h0600, w);
    // Falling sense, so the comparator drop below would match if enabled
    set_mode(4'hc, CS_STOP, 1'b0);
    chk("mode12", 16'h000c, {12'h0, wmode});
    cpu.wr16(ADR_CAP_LO, 16'h0300);
    cpu.rd16(ADR_CAP_LO, w);
    chk("cap_top", 16'h0300, w);
    cpu.wr16(ADR_CNT_LO, 16'h0300);
    comp = 1'b0;
    repeat (4) @(negedge clk);
    chk("top_cap", 16'h0001, {15'h0, top});
    cpu.rd(ADR_FLAGS, b);
    chk("cap_off", 16'h0000, {15'h0, b[FLAG_CAP_BIT]});
    cpu.rd16(ADR_CAP_LO, w);
    chk("cap_hold", 16'h0300, w);
    $display("t_captop done");
  endtask
  // Hang guard
  initial begin
    #200us;
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    nrst_n = 1'b0;
    ext = 1'b0;
    pin = 1'b0;
    comp = 1'b0;
    csel = 1'b0;
    repeat (10) @(negedge clk);
    nrst_n = 1'b1;
    t_reset();
    t_word();
    t_latch();
    t_ext();
    t_ovf();
    t_dual();
    t_cap();
    t_captop();
    test_done();
  end
endmodule
